// ---- verilog/llbs_map.svh ----
// Register map, field layout and timing constants of the burst sequencer.
`ifndef LLBS_MAP_SVH
`define LLBS_MAP_SVH
// Register byte offsets.
`define LLBS_CTRL_OFS 8'h00
`define LLBS_HSW_OFS 8'h04
`define LLBS_BLANK_OFS 8'h08
`define LLBS_TON_OFS 8'h0C
`define LLBS_STAT_OFS 8'h10
`define LLBS_PER_OFS 8'h14
// Reset values of the timing registers, in clock cycles.
`define LLBS_HSW_RST 8'h10
`define LLBS_BLANK_RST 8'h0A
`define LLBS_TON_RST 8'h04
// Status field positions.
`define LLBS_STAT_MODE_LSB 0
`define LLBS_STAT_PPP_LSB 8
`define LLBS_STAT_SINK_BIT 12
`define LLBS_STAT_VSHI_BIT 13
// Clock rate and period.
`define LLBS_CLK_HZ 40000000
`define LLBS_CLK_PER_NS 25
// Least wait: run low between packets, and run high before a pulse.
`define LLBS_T_WAIT_NS 2200
`define LLBS_WAIT_CYC ((`LLBS_T_WAIT_NS+`LLBS_CLK_PER_NS-1)/`LLBS_CLK_PER_NS)
// Burst rate thresholds in hertz; periods in cycles follow from them.
`define LLBS_F_LR_HZ 25000
`define LLBS_F_UP2_HZ 50000
`define LLBS_F_UP1_HZ 34000
`define LLBS_F_SB_UP_HZ 8500
`define LLBS_F_SB_LR_HZ 1700
`define LLBS_CYC(f) (`LLBS_CLK_HZ / (f))
// Pulses per packet limits.
`define LLBS_PPP_MIN 2
`define LLBS_PPP_MAX_LO 5
`define LLBS_PPP_MAX_HI 9
`define LLBS_PPP_UP2_TOP 3
`define LLBS_PPP_SB2 (2 * `LLBS_PPP_MIN)
// Bundle history depth, hits that enable the sink, low-rate streak.
`define LLBS_BUND_DEPTH 8
`define LLBS_BUND_HITS 2
`define LLBS_LR_STREAK 2
`endif

// ---- verilog/llbs_pkg.sv ----
// Types shared by the burst sequencer.
`default_nettype none
package llbs_pkg;
  // Operating mode, one-hot.
  typedef enum logic [4:0] {
    AMPLITUDE_MOD_STATE = 5'h01,
    ADAPTIVE_BURST_STATE = 5'h02,
    LOW_POWER_STATE = 5'h04,
    FIRST_STANDBY_STATE = 5'h08,
    SECOND_STANDBY_STATE = 5'h10
  } llbs_mode_t;
  // Packet sequencer state, one-hot.
  typedef enum logic [5:0] {
    SQ_IDLE = 6'h01,
    SQ_WAKE = 6'h02,
    SQ_ZC1 = 6'h04,
    SQ_LS = 6'h08,
    SQ_HS = 6'h10,
    SQ_ZCE = 6'h20
  } llbs_seq_t;
  // Comparator and strap pins, synchronised together.
  typedef struct packed {
    logic burst_req;
    logic switch_ref;
    logic standby_peak_pin_high;
    logic peak_at_min;
    logic vs_high;
    logic vs_low;
    logic zero_cross_detect;
    logic cs_trip;
    logic cs_at_burst;
  } llbs_pins_t;
endpackage
`default_nettype wire

// ---- verilog/llbs_top.sv ----
// Light-load burst sequencer with its APB register slave.
`timescale 1ns/100ps
`default_nettype none
`include "llbs_map.svh"

// Notes on behaviour
// - Burst level reached enters burst, clamps peak.
// - Run stays low at least 2.2 us.
// - Packet opens with low-side pulse first.
// - First low-side at zero cross; later high-side.
// - Target reached: run drops at last crossing.
// - Burst low-side width not below blanking.
// - Rate down to 25 kHz: one pulse less.
// - Rate up to upper limit: one pulse more.
// - Low sense range: cap five, 50 kHz.
// - High range: cap nine, 50/34 kHz.
// - Standby peak pin ignored in burst mode.
// - Two bundles in eight bursts: sink on.
// - Two pulses, two slow periods: low power.
// - Low power: two pulses, run drops.
// - Reference strap: pulse width regulation, short.
// - Ground strap: width still limited by blanking.
// - Minimum peak: first standby, two pulses.
// - Below 8.5 kHz: second standby.
// - Second standby doubles pulses per packet.
// - Second standby peak from standby pin.
// - Pin low: minimum peak, exit above 8.5k.
// - Pin high: exit only above 1.7 kHz.
// - Run high 2.2 us before first pulse.
module llbs_top #(
  parameter int P_SB_UP_CYC = `LLBS_CYC(`LLBS_F_SB_UP_HZ),
  parameter int P_SB_LR_CYC = `LLBS_CYC(`LLBS_F_SB_LR_HZ)
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // APB slave.
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Comparator and strap pins.
  input wire llbs_pkg::llbs_pins_t pins_in,
  // Gate driver wake and gate pulses.
  output logic run_out,
  output logic low_side_gate_pulse_out,
  output logic high_side_gate_pulse_out,
  // Analog loop controls.
  output logic burst_level_pin_sink_out,
  output logic peak_clamp_burst_out,
  output logic peak_min_out,
  output logic peak_from_pin_out,
  output logic voltage_mode_out
);

  // Period thresholds in cycles.
  localparam int WAIT_CYC = `LLBS_WAIT_CYC;
  localparam logic [15:0] LR_C = 16'(`LLBS_CYC(`LLBS_F_LR_HZ));
  localparam logic [15:0] UP2_C = 16'(`LLBS_CYC(`LLBS_F_UP2_HZ));
  localparam logic [15:0] UP1_C = 16'(`LLBS_CYC(`LLBS_F_UP1_HZ));
  localparam logic [15:0] SBU_C = 16'(P_SB_UP_CYC);
  localparam logic [15:0] SBL_C = 16'(P_SB_LR_CYC);
  localparam logic [7:0] WAIT_C = 8'(WAIT_CYC);
  localparam int NP = $bits(llbs_pkg::llbs_pins_t);

  // Refuse thresholds the 16-bit period counter cannot hold.
  if (P_SB_LR_CYC > 65534 || P_SB_UP_CYC >= P_SB_LR_CYC ||
      P_SB_UP_CYC <= int'(LR_C)) begin : g_chk
    $error("Standby period parameters out of range.");
  end

  // Pin sampling: three flops, a change counts when two agree.
  logic [NP-1:0] raw;
  logic [NP-1:0] cln_q;
  llbs_pkg::llbs_pins_t pin;
  assign raw = pins_in;
  assign pin = cln_q;
  for (genvar gi = 0; gi < NP; gi++) begin : g_sync
    logic [2:0] s_q;
    always_ff @(posedge core_clk_in) begin
      if (!resetn_in) begin
        s_q <= 3'h0;
        cln_q[gi] <= 1'b0;
      end else begin
        s_q <= {s_q[1:0], raw[gi]};
        if (s_q[1] == s_q[2]) begin
          cln_q[gi] <= s_q[1];
        end
      end
    end
  end

  // Zero crossing edge on the cleaned pin.
  logic zc_old_q;
  logic zc_edge;
  assign zc_edge = pin.zero_cross_detect & ~zc_old_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      zc_old_q <= 1'b0;
    end else begin
      zc_old_q <= pin.zero_cross_detect;
    end
  end

  // Control registers and APB outputs.
  logic en_q;
  logic [7:0] hsw_q;
  logic [7:0] blank_q;
  logic [7:0] ton_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic setup;
  logic acc;
  logic hit;
  logic [31:0] rd_val;
  // Block state seen by the status registers.
  llbs_pkg::llbs_mode_t mode_q;
  llbs_pkg::llbs_seq_t sq_q;
  logic [3:0] ppp_q;
  logic [15:0] per_q;
  logic sink_q;
  logic vs_hi_q;

  // A setup cycle is answered in the following access cycle.
  assign setup = psel_in & ~penable_in;
  assign acc = psel_in & penable_in & pready_q;
  assign hit = (paddr_in[1:0] == 2'h0) && (paddr_in <= `LLBS_PER_OFS);

  // Read data mux; unmapped addresses read as zero.
  always_comb begin
    rd_val = 32'h0;
    case (paddr_in)
      `LLBS_CTRL_OFS: rd_val[0] = en_q;
      `LLBS_HSW_OFS: rd_val[7:0] = hsw_q;
      `LLBS_BLANK_OFS: rd_val[7:0] = blank_q;
      `LLBS_TON_OFS: rd_val[7:0] = ton_q;
      `LLBS_STAT_OFS: begin
        rd_val[`LLBS_STAT_MODE_LSB +: 5] = mode_q;
        rd_val[`LLBS_STAT_PPP_LSB +: 4] = ppp_q;
        rd_val[`LLBS_STAT_SINK_BIT] = sink_q;
        rd_val[`LLBS_STAT_VSHI_BIT] = vs_hi_q;
      end
      `LLBS_PER_OFS: rd_val[15:0] = per_q;
      default: rd_val = 32'h0;
    endcase
  end

  // Bus handshake: ready, read data and error set up together.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup & ~hit;
      prdata_q <= (setup & ~pwrite_in) ? rd_val : 32'h0;
    end
  end

  // Register writes land at the access edge only.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      en_q <= 1'b0;
      hsw_q <= `LLBS_HSW_RST;
      blank_q <= `LLBS_BLANK_RST;
      ton_q <= `LLBS_TON_RST;
    end else if (acc && pwrite_in) begin
      case (paddr_in)
        `LLBS_CTRL_OFS: en_q <= pwdata_in[0];
        `LLBS_HSW_OFS: hsw_q <= pwdata_in[7:0];
        `LLBS_BLANK_OFS: blank_q <= pwdata_in[7:0];
        `LLBS_TON_OFS: ton_q <= pwdata_in[7:0];
        default: en_q <= en_q;
      endcase
    end
  end

  // Sequencer working values.
  logic [7:0] off_q;
  logic [7:0] wk_q;
  logic [7:0] lcnt_q;
  logic [7:0] hcnt_q;
  logic [3:0] pcnt_q;
  logic [3:0] tgt_q;
  logic [15:0] pcnt16_q;
  logic run_q;
  logic ls_q;
  logic hs_q;
  logic pkt_start;
  logic vm;
  logic [7:0] minw;
  logic [3:0] tgt_d;
  logic [3:0] maxp;
  logic [15:0] up_c;
  logic ls_end;

  // Packet may start after the least wait on a loop request.
  assign pkt_start = (sq_q == llbs_pkg::SQ_IDLE) && en_q &&
    (mode_q != llbs_pkg::AMPLITUDE_MOD_STATE) &&
    (off_q >= WAIT_C) && pin.burst_req;
  // Width regulation only in low power with the reference strap.
  assign vm = (mode_q == llbs_pkg::LOW_POWER_STATE) & pin.switch_ref;
  assign minw = vm ? ton_q : blank_q;
  assign ls_end = vm ? (lcnt_q >= ton_q) :
    (pin.cs_trip && (lcnt_q >= minw));
  // Cap and upper limit follow the sampled sense range.
  assign maxp = vs_hi_q ? 4'(`LLBS_PPP_MAX_HI) : 4'(`LLBS_PPP_MAX_LO);
  assign up_c = (vs_hi_q && ppp_q > 4'(`LLBS_PPP_UP2_TOP)) ?
    UP1_C : UP2_C;

  // Target pulse count of the packet about to start.
  always_comb begin
    case (mode_q)
      llbs_pkg::ADAPTIVE_BURST_STATE: tgt_d = ppp_q;
      llbs_pkg::SECOND_STANDBY_STATE: tgt_d = 4'(`LLBS_PPP_SB2);
      default: tgt_d = 4'(`LLBS_PPP_MIN);
    endcase
  end

  // Packet sequencer: wake, zero cross, low side, high side, end.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sq_q <= llbs_pkg::SQ_IDLE;
      run_q <= 1'b0;
      ls_q <= 1'b0;
      hs_q <= 1'b0;
      off_q <= 8'h0;
      wk_q <= 8'h0;
      lcnt_q <= 8'h0;
      hcnt_q <= 8'h0;
      pcnt_q <= 4'h0;
      tgt_q <= 4'h0;
    end else if (!en_q || mode_q == llbs_pkg::AMPLITUDE_MOD_STATE) begin
      // Heavy load keeps the driver awake; this block stays idle.
      sq_q <= llbs_pkg::SQ_IDLE;
      run_q <= en_q;
      ls_q <= 1'b0;
      hs_q <= 1'b0;
      off_q <= 8'h0;
    end else begin
      case (sq_q)
        llbs_pkg::SQ_IDLE: begin
          run_q <= 1'b0;
          if (off_q != 8'hFF) begin
            off_q <= off_q + 8'h1;
          end
          if (pkt_start) begin
            sq_q <= llbs_pkg::SQ_WAKE;
            run_q <= 1'b1;
            wk_q <= 8'h0;
            pcnt_q <= 4'h0;
            tgt_q <= tgt_d;
          end
        end
        llbs_pkg::SQ_WAKE: begin
          // Hold off the first pulse until the driver is awake.
          wk_q <= wk_q + 8'h1;
          if (wk_q >= WAIT_C - 8'h1) begin
            sq_q <= llbs_pkg::SQ_ZC1;
          end
        end
        llbs_pkg::SQ_ZC1: begin
          // First low-side pulse opens at a crossing.
          if (zc_edge) begin
            sq_q <= llbs_pkg::SQ_LS;
            ls_q <= 1'b1;
            lcnt_q <= 8'h0;
          end
        end
        llbs_pkg::SQ_LS: begin
          lcnt_q <= lcnt_q + 8'h1;
          if (ls_end) begin
            ls_q <= 1'b0;
            pcnt_q <= pcnt_q + 4'h1;
            if (mode_q == llbs_pkg::ADAPTIVE_BURST_STATE) begin
              sq_q <= llbs_pkg::SQ_HS;
              hs_q <= 1'b1;
              hcnt_q <= 8'h0;
            end else begin
              sq_q <= llbs_pkg::SQ_ZCE;
            end
          end
        end
        llbs_pkg::SQ_HS: begin
          hcnt_q <= hcnt_q + 8'h1;
          if (hcnt_q >= hsw_q) begin
            hs_q <= 1'b0;
            sq_q <= llbs_pkg::SQ_ZCE;
          end
        end
        llbs_pkg::SQ_ZCE: begin
          if (zc_edge) begin
            if (pcnt_q >= tgt_q) begin
              sq_q <= llbs_pkg::SQ_IDLE;
              run_q <= 1'b0;
              off_q <= 8'h0;
            end else begin
              sq_q <= llbs_pkg::SQ_LS;
              ls_q <= 1'b1;
              lcnt_q <= 8'h0;
            end
          end
        end
        default: sq_q <= llbs_pkg::SQ_IDLE;
      endcase
    end
  end

  // Sense range sampled at the high-side falling edge, with hysteresis.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      vs_hi_q <= 1'b0;
    end else if (sq_q == llbs_pkg::SQ_HS && hcnt_q >= hsw_q) begin
      if (pin.vs_high) begin
        vs_hi_q <= 1'b1;
      end else if (pin.vs_low) begin
        vs_hi_q <= 1'b0;
      end
    end
  end

  // Burst period counter, restarted at every packet start.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pcnt16_q <= 16'h0;
      per_q <= 16'h0;
    end else if (pkt_start) begin
      per_q <= pcnt16_q;
      pcnt16_q <= 16'h0;
    end else if (pcnt16_q != 16'hFFFF) begin
      pcnt16_q <= pcnt16_q + 16'h1;
    end
  end

  // Mode stepping and pulses per packet; rate steps judged at packet start.
  logic [1:0] lr_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_q <= llbs_pkg::AMPLITUDE_MOD_STATE;
      ppp_q <= 4'(`LLBS_PPP_MAX_LO);
      lr_q <= 2'h0;
    end else if (!en_q) begin
      mode_q <= llbs_pkg::AMPLITUDE_MOD_STATE;
      lr_q <= 2'h0;
    end else begin
      case (mode_q)
        llbs_pkg::AMPLITUDE_MOD_STATE: begin
          if (pin.cs_at_burst) begin
            mode_q <= llbs_pkg::ADAPTIVE_BURST_STATE;
          end
        end
        llbs_pkg::ADAPTIVE_BURST_STATE: begin
          // The standby peak pin takes no part here.
          if (!pin.cs_at_burst) begin
            mode_q <= llbs_pkg::AMPLITUDE_MOD_STATE;
          end else if (pkt_start && pcnt16_q >= LR_C) begin
            if (ppp_q > 4'(`LLBS_PPP_MIN)) begin
              ppp_q <= ppp_q - 4'h1;
              lr_q <= 2'h0;
            end else if (lr_q == 2'(`LLBS_LR_STREAK - 1)) begin
              mode_q <= llbs_pkg::LOW_POWER_STATE;
              lr_q <= 2'h0;
            end else begin
              lr_q <= lr_q + 2'h1;
            end
          end else if (pkt_start) begin
            lr_q <= 2'h0;
            if (pcnt16_q <= up_c && ppp_q < maxp) begin
              ppp_q <= ppp_q + 4'h1;
            end
          end else if (ppp_q > maxp) begin
            ppp_q <= maxp;
          end
        end
        llbs_pkg::LOW_POWER_STATE: begin
          if (pin.peak_at_min) begin
            mode_q <= llbs_pkg::FIRST_STANDBY_STATE;
          end
        end
        llbs_pkg::FIRST_STANDBY_STATE: begin
          if (!pin.peak_at_min) begin
            mode_q <= llbs_pkg::LOW_POWER_STATE;
          end else if (pkt_start && pcnt16_q > SBU_C) begin
            mode_q <= llbs_pkg::SECOND_STANDBY_STATE;
          end
        end
        llbs_pkg::SECOND_STANDBY_STATE: begin
          // Pin high skips the band between the two exit rates.
          if (pkt_start && pcnt16_q <
              (pin.standby_peak_pin_high ? SBL_C : SBU_C)) begin
            mode_q <= llbs_pkg::FIRST_STANDBY_STATE;
          end
        end
        default: mode_q <= llbs_pkg::AMPLITUDE_MOD_STATE;
      endcase
    end
  end

  // Bundle history: max-count packets started at the least wait.
  logic [`LLBS_BUND_DEPTH-1:0] bund_q;
  logic [`LLBS_BUND_DEPTH-1:0] bund_d;
  logic bund_now;
  assign bund_now = (ppp_q == maxp) && (off_q == WAIT_C);
  assign bund_d = {bund_q[`LLBS_BUND_DEPTH-2:0], bund_now};
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      bund_q <= '0;
      sink_q <= 1'b0;
    end else if (pkt_start &&
                 mode_q == llbs_pkg::ADAPTIVE_BURST_STATE) begin
      bund_q <= bund_d;
      if ($countones(bund_d) >= `LLBS_BUND_HITS) begin
        sink_q <= 1'b1;
      end
    end else if (mode_q == llbs_pkg::AMPLITUDE_MOD_STATE) begin
      bund_q <= '0;
      sink_q <= 1'b0;
    end
  end

  // Peak threshold selection toward the analog loop.
  logic clamp_q;
  logic pmin_q;
  logic ppin_q;
  logic vm_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      clamp_q <= 1'b0;
      pmin_q <= 1'b0;
      ppin_q <= 1'b0;
      vm_q <= 1'b0;
    end else begin
      clamp_q <= mode_q == llbs_pkg::ADAPTIVE_BURST_STATE;
      pmin_q <= (mode_q == llbs_pkg::FIRST_STANDBY_STATE) ||
        (mode_q == llbs_pkg::SECOND_STANDBY_STATE &&
         !pin.standby_peak_pin_high);
      ppin_q <= (mode_q == llbs_pkg::SECOND_STANDBY_STATE) &&
        pin.standby_peak_pin_high;
      vm_q <= vm;
    end
  end

  // Outputs straight from flops.
  assign prdata_out = prdata_q;
  assign pready_out = pready_q;
  assign pslverr_out = pslverr_q;
  assign run_out = run_q;
  assign low_side_gate_pulse_out = ls_q;
  assign high_side_gate_pulse_out = hs_q;
  assign burst_level_pin_sink_out = sink_q;
  assign peak_clamp_burst_out = clamp_q;
  assign peak_min_out = pmin_q;
  assign peak_from_pin_out = ppin_q;
  assign voltage_mode_out = vm_q;

  // Helpers: run age and low-side seen in this packet.
  logic [7:0] age_q;
  logic seen_q;
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !run_q) begin
      age_q <= 8'h0;
      seen_q <= 1'b0;
    end else begin
      if (age_q != 8'hFF) begin
        age_q <= age_q + 8'h1;
      end
      if (ls_q) begin
        seen_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!resetn_in);

  // Last crossing of a full packet.
  sequence zc_last_s;
    sq_q == llbs_pkg::SQ_ZCE && zc_edge && pcnt_q >= tgt_q &&
    en_q && mode_q != llbs_pkg::AMPLITUDE_MOD_STATE;
  endsequence
  // A packet start judged slow in burst mode with pulses to spare.
  sequence slow_s;
    pkt_start && mode_q == llbs_pkg::ADAPTIVE_BURST_STATE &&
    pin.cs_at_burst && pcnt16_q >= LR_C && ppp_q > 4'(`LLBS_PPP_MIN);
  endsequence

  wait_min_a: assert property (
    pkt_start |-> off_q >= WAIT_C && !run_q)
    else $error("Run rose before the least wait.");
  wake_delay_a: assert property (
    $rose(ls_q) |-> age_q >= WAIT_C)
    else $error("Low-side pulse too soon after run.");
  ls_first_a: assert property (
    $rose(hs_q) |-> seen_q && !ls_q)
    else $error("High-side pulse before low-side.");
  zc_first_a: assert property (
    sq_q == llbs_pkg::SQ_ZC1 && zc_edge && en_q |=> ls_q)
    else $error("First low-side pulse missed crossing.");
  run_drop_a: assert property (
    zc_last_s |=> !run_q ##1 (!run_q ||
      mode_q == llbs_pkg::AMPLITUDE_MOD_STATE))
    else $error("Run not dropped after last crossing.");
  ls_min_a: assert property (
    $fell(ls_q) && !$past(vm) |-> $past(lcnt_q) >= $past(blank_q))
    else $error("Low-side pulse shorter than blanking.");
  down_step_a: assert property (
    slow_s |=> ppp_q == $past(ppp_q) - 4'h1)
    else $error("Pulses not reduced on slow burst.");
  cap_a: assert property (
    !vs_hi_q && mode_q == llbs_pkg::ADAPTIVE_BURST_STATE
    && !$changed(vs_hi_q) |=> ppp_q <= 4'(`LLBS_PPP_MAX_LO))
    else $error("Pulses above low-range cap.");
  hs_off_a: assert property (
    mode_q != llbs_pkg::ADAPTIVE_BURST_STATE |=> !$rose(hs_q))
    else $error("High-side pulse outside burst mode.");
  sb2_count_a: assert property (
    pkt_start && mode_q == llbs_pkg::SECOND_STANDBY_STATE
    |=> tgt_q == 4'(`LLBS_PPP_SB2))
    else $error("Second standby packet not doubled.");
  sink_a: assert property (
    sink_q && $past(sink_q) |->
    $past(mode_q) != llbs_pkg::AMPLITUDE_MOD_STATE)
    else $error("Sink on outside burst operation.");

endmodule // llbs_top
`default_nettype wire

// ---- sim/llbs_stage_model.sv ----
// Behavioural power stage: winding ringing and current-sense trip.
`timescale 1ns/100ps
`default_nettype none
module llbs_stage_model #(
  parameter int P_TRIP_CYC = 4,
  parameter int P_RING_CYC = 12
) (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic resetn_in,
  // Gate driver side.
  input wire logic run_in,
  input wire logic low_side_in,
  input wire logic high_side_in,
  // Sensed comparator levels.
  output var logic zero_cross_out,
  output var logic cs_trip_out
);
  // Cycles of low-side conduction and of ringing.
  int on_cnt;
  int ring_cnt;
  // Current ramps while the low side conducts and trips after a fixed ramp.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !low_side_in) begin
      on_cnt <= 0;
      cs_trip_out <= 1'b0;
    end else begin
      on_cnt <= on_cnt + 1;
      cs_trip_out <= (on_cnt >= P_TRIP_CYC);
    end
  end
  // The winding rings while run is high and both gates are off, one crossing per period.
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in || !run_in || low_side_in || high_side_in) begin
      ring_cnt <= 0;
      zero_cross_out <= 1'b0;
    end else begin
      ring_cnt <= (ring_cnt == P_RING_CYC - 1) ? 0 : ring_cnt + 1;
      zero_cross_out <= (ring_cnt >= P_RING_CYC / 2);
    end
  end
endmodule // llbs_stage_model
`default_nettype wire

// ---- sim/light_load_burst_sequencer_test.sv ----
// Self-checking bench of the light-load burst sequencer.
`timescale 1ns/100ps
`default_nettype none
`include "llbs_map.svh"
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
  failures++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module light_load_burst_sequencer_test;
  // Clock, reset and counters.
  logic core_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int cyc = 0;
  int low_cnt = 1000;
  // APB master signals.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  // Pins from the bench and the stage model.
  llbs_pkg::llbs_pins_t pins_drv = '0;
  llbs_pkg::llbs_pins_t pins_w;
  wire logic run, ls, hs, zc, trip;
  always_comb begin
    pins_w = pins_drv;
    pins_w.zero_cross_detect = zc;
    pins_w.cs_trip = trip;
  end
  // Clock at 40 MHz.
  always #12.5 core_clk_in = ~core_clk_in;
  llbs_top #(.P_SB_UP_CYC(2000), .P_SB_LR_CYC(3000)) i_dut (
    .core_clk_in(core_clk_in), .resetn_in(resetn_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
    .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
    .pslverr_out(pslverr), .pins_in(pins_w), .run_out(run),
    .low_side_gate_pulse_out(ls), .high_side_gate_pulse_out(hs),
    .burst_level_pin_sink_out(), .peak_clamp_burst_out(),
    .peak_min_out(), .peak_from_pin_out(), .voltage_mode_out());
  llbs_stage_model i_stage (.core_clk_in(core_clk_in),
    .resetn_in(resetn_in), .run_in(run), .low_side_in(ls),
    .high_side_in(hs), .zero_cross_out(zc), .cs_trip_out(trip));
  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Watches the run-low gap before each rise, and cuts a hang short.
  always @(posedge core_clk_in) begin
    cyc++;
    if (run === 1'b1 && low_cnt > 0) `CHK("run gap", 1'b1, low_cnt >= 88)
    low_cnt = (run === 1'b1) ? 0 : low_cnt + 1;
    if (cyc == 90000) begin
      failures++;
      final_report();
    end
  end
  // One APB transfer; waits for pready with no bound, then checks it came after one cycle.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge core_clk_in);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge core_clk_in);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    `CHK("pready wait", 1, n)
    `CHK("pslverr", a > 8'h14, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Reads the status mode field and compares it.
  task automatic mode_is(input logic [4:0] ex);
    logic [31:0] rd;
    apb(1'b0, `LLBS_STAT_OFS, 32'h0, rd);
    `CHK("mode", ex, rd[4:0])
  endtask
  // Requests one packet after an idle gap and counts its gate pulses.
  task automatic packet(input int gap, input int ex_ls, input int ex_hs);
    int n, wake, n_ls, n_hs, w, minw;
    logic hs_q, hs_early;
    n = 0;
    wake = 0;
    n_ls = 0;
    n_hs = 0;
    w = 0;
    minw = 999;
    hs_q = 1'b0;
    hs_early = 1'b0;
    repeat (gap) @(posedge core_clk_in);
    pins_drv.burst_req <= 1'b1;
    while (run !== 1'b1) begin
      @(posedge core_clk_in);
      n++;
    end
    pins_drv.burst_req <= 1'b0;
    while (run === 1'b1) begin
      @(posedge core_clk_in);
      n++;
      if (n_ls == 0 && w == 0 && ls !== 1'b1) wake++;
      if (ls === 1'b1) begin
        w++;
      end else if (w > 0) begin
        n_ls++;
        minw = (w < minw) ? w : minw;
        w = 0;
      end
      if (hs === 1'b1 && n_ls == 0) hs_early = 1'b1;
      if (hs === 1'b1 && hs_q !== 1'b1) n_hs++;
      hs_q = hs;
    end
    `CHK("wake", 1'b1, wake >= 88)
    `CHK("hs first", 1'b0, hs_early)
    `CHK("ls width", 1'b1, minw >= `LLBS_BLANK_RST + 1)
    if (ex_ls >= 0) `CHK("ls count", ex_ls, n_ls)
    if (ex_hs >= 0) `CHK("hs count", ex_hs, n_hs)
  endtask
  // Main sequence.
  initial begin
    logic [31:0] rd;
    logic [31:0] rst_tbl [5];
    rst_tbl = '{32'h0, `LLBS_HSW_RST, `LLBS_BLANK_RST, `LLBS_TON_RST,
                32'h501};
    repeat (5) @(posedge core_clk_in);
    resetn_in <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0, rd);
      `CHK("reset value", rst_tbl[i], rd)
    end
    apb(1'b0, 8'h20, 32'h0, rd);
    `CHK("unmapped", 32'h0, rd)
    apb(1'b1, `LLBS_CTRL_OFS, 32'h1, rd);
    pins_drv.vs_low <= 1'b1;
    pins_drv.standby_peak_pin_high <= 1'b1;
    pins_drv.cs_at_burst <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    `CHK("clamp", 1'b1, i_dut.peak_clamp_burst_out)
    mode_is(llbs_pkg::ADAPTIVE_BURST_STATE);
    // A new count takes effect from the packet after the one judged.
    packet(2000, 5, 5);
    packet(0, 4, 4);
    packet(0, 5, 5);
    `CHK("sink", 1'b0, i_dut.burst_level_pin_sink_out)
    packet(0, 5, 5);
    `CHK("sink", 1'b1, i_dut.burst_level_pin_sink_out)
    packet(2000, 5, 5);
    packet(2000, 4, 4);
    packet(2000, 3, 3);
    packet(2000, 2, 2);
    packet(2000, 2, 0);
    packet(2000, 2, 0);
    mode_is(llbs_pkg::LOW_POWER_STATE);
    `CHK("volt mode", 1'b0, i_dut.voltage_mode_out)
    pins_drv.switch_ref <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    `CHK("volt mode", 1'b1, i_dut.voltage_mode_out)
    pins_drv.switch_ref <= 1'b0;
    repeat (10) @(posedge core_clk_in);
    `CHK("volt mode", 1'b0, i_dut.voltage_mode_out)
    pins_drv.peak_at_min <= 1'b1;
    repeat (10) @(posedge core_clk_in);
    mode_is(llbs_pkg::FIRST_STANDBY_STATE);
    `CHK("peak min", 1'b1, i_dut.peak_min_out)
    packet(2000, 2, 0);
    packet(3000, 4, 0);
    mode_is(llbs_pkg::SECOND_STANDBY_STATE);
    `CHK("peak pin", 1'b1, i_dut.peak_from_pin_out)
    packet(2300, 4, 0);
    mode_is(llbs_pkg::FIRST_STANDBY_STATE);
    final_report();
  end
endmodule // light_load_burst_sequencer_test
`default_nettype wire
